// ===== common/adcsc_defs.vh
// constants for the serial conversion control block
`ifndef ADCSC_DEFS_VH
`define ADCSC_DEFS_VH
`define ADCSC_FRAME_EDGES   5'd16
`define ADCSC_TRACK_EDGE    5'd14
`define ADCSC_PD_LO_EDGE    5'd3
`define ADCSC_MSB_EDGE      5'd4
`define ADCSC_LAST_DATA     5'd13
`define ADCSC_SUB_HI_EDGE   5'd14
`define ADCSC_SUB_LO_EDGE   5'd15
`define ADCSC_RES_BITS      10
`define ADCSC_MODE_RUN      2'd0
`define ADCSC_MODE_PARTIAL  2'd1
`define ADCSC_MODE_FULL     2'd2
`define ADCSC_ST_IDLE       2'd0
`define ADCSC_ST_CONV       2'd1
`define ADCSC_ST_DONE       2'd2
`define ADCSC_CNT_ZERO      5'd0
`define ADCSC_CNT_ONE       5'd1
`endif

// ===== rtl/adcsc_skid_buffer.v
// two-entry buffer carrying finished results to the result port
`timescale 1ns/10ps
`include "adcsc_defs.vh"
module adcsc_skid_buffer (
  // clock and reset
  input  wire        sys_clk,
  input  wire        reset,
  // fill side
  input  wire        inValid,
  output wire        inReady,
  input  wire [11:0] inData,
  // drain side
  output wire        outValid,
  input  wire        outReady,
  output wire [11:0] outData
);
  reg  [11:0] mem_q [0:1];
  reg         wrPtr_q;
  reg         rdPtr_q;
  reg  [1:0]  count_q;
  wire        doWrite;
  wire        doRead;

  assign inReady  = (count_q != 2'd2);
  assign outValid = (count_q != 2'd0);
  assign outData  = mem_q[rdPtr_q];
  assign doWrite  = inValid & inReady;
  assign doRead   = outValid & outReady;

  // pointer and occupancy; full stalls the producer
  always @(posedge sys_clk) begin
    if (reset) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'd0;
    end else begin
      if (doWrite) begin
        mem_q[wrPtr_q] <= inData;
        wrPtr_q        <= ~wrPtr_q;
      end
      if (doRead)
        rdPtr_q <= ~rdPtr_q;
      count_q <= count_q + {1'b0, doWrite} - {1'b0, doRead};
    end
  end
endmodule

// ===== rtl/adcsc_conv_ctrl.v
// conversion sequencing and serial output of a 10-bit sar converter
// Notes on behaviour
// - strobe fall starts conversion, freezes input
// - hold begins on the sys_clk edge that sees strobe fall
// - output updates on serial clock rising edges
// - sixteen clock cycles per conversion
// - only host clock edges advance conversion
// - back to tracking at 14th rising edge
// - idle between conversions in tracking
// - two-and-a-half-cycle acquisition at full speed
// - tracking straight after power-up
// - ten-bit successive approximation, bit per step
// - frame: 3 zeros, 10 bits, 2 sub-bits, zero
// - strobe low at 16th fall: output floats at next clock or strobe rise
// - early strobe rise enters partial, then full
`timescale 1ns/10ps
`include "adcsc_defs.vh"
module adcsc_conv_ctrl (
  // system clock and reset (reset models power-up)
  input  wire        sys_clk,
  input  wire        reset,
  // host serial pins, sampled on sys_clk
  input  wire        convStrobe,
  input  wire        serialClk,
  output reg         dataOut,
  output reg         dataOutEn,
  // analog front end control
  output reg         trackEn,
  output reg         compTrialBit,
  input  wire        compResult,
  output reg  [9:0]  dacCode,
  // power mode
  output reg  [1:0]  powerMode,
  // finished results
  output reg         resultValid,
  input  wire        resultReady,
  output reg  [11:0] resultData
);
  // ==========================================================
  // input edge detection
  // ==========================================================
  reg         strobe_q;
  reg         sclk_q;
  wire        strobeFall;
  wire        strobeRise;
  wire        sclkRise;
  wire        sclkFall;

  assign strobeFall = strobe_q & ~convStrobe;
  assign strobeRise = ~strobe_q & convStrobe;
  assign sclkRise   = ~sclk_q & serialClk;
  assign sclkFall   = sclk_q & ~serialClk;

  // previous pin levels; pins are already synchronous
  always @(posedge sys_clk) begin
    if (reset) begin
      strobe_q <= 1'b1;
      sclk_q   <= 1'b0;
    end else begin
      strobe_q <= convStrobe;
      sclk_q   <= serialClk;
    end
  end

  // ==========================================================
  // conversion sequencer
  // ==========================================================
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [4:0]  riseCnt_q;
  reg  [4:0]  fallCnt_q;
  reg  [11:0] sar_q;
  reg         floatArm_q;
  reg         earlyRise_q;
  wire        bufReady;
  wire        bufValid;
  wire [11:0] bufData;
  reg         push_q;
  reg  [11:0] pushData_q;
  wire [3:0]  bitIdx;
  wire [4:0]  dataPos;

  // position in the frame: edge 4 gives msb, edges 4..13 the ten bits
  // the counter still holds the previous edge number when the new edge is seen
  assign dataPos = riseCnt_q - (`ADCSC_MSB_EDGE - `ADCSC_CNT_ONE);
  assign bitIdx  = 4'd9 - dataPos[3:0];

  // next-state selection
  always @* begin
    state_d = state_q;
    case (state_q)
      `ADCSC_ST_IDLE: begin
        if (strobeFall)
          state_d = `ADCSC_ST_CONV;
      end
      `ADCSC_ST_CONV: begin
        if (strobeFall)
          state_d = `ADCSC_ST_CONV;
        else if (strobeRise && riseCnt_q >= `ADCSC_PD_LO_EDGE && riseCnt_q < `ADCSC_TRACK_EDGE)
          state_d = `ADCSC_ST_IDLE;
        else if (sclkFall && fallCnt_q == `ADCSC_FRAME_EDGES - `ADCSC_CNT_ONE)
          state_d = `ADCSC_ST_DONE;
      end
      `ADCSC_ST_DONE: begin
        if (strobeFall)
          state_d = `ADCSC_ST_CONV;
        else if (strobeRise || sclkRise || convStrobe)
          state_d = `ADCSC_ST_IDLE;
      end
      default: state_d = `ADCSC_ST_IDLE;
    endcase
  end

  // state, counters and successive approximation register
  // a strobe fall always restarts the frame, even mid-conversion
  always @(posedge sys_clk) begin
    if (reset) begin
      state_q      <= `ADCSC_ST_IDLE;
      riseCnt_q    <= `ADCSC_CNT_ZERO;
      fallCnt_q    <= `ADCSC_CNT_ZERO;
      sar_q        <= 12'h000;
      trackEn      <= 1'b1;
      dataOut      <= 1'b0;
      dataOutEn    <= 1'b0;
      compTrialBit <= 1'b0;
      dacCode      <= 10'h000;
      earlyRise_q  <= 1'b0;
      floatArm_q   <= 1'b0;
      powerMode    <= `ADCSC_MODE_RUN;
      push_q       <= 1'b0;
      pushData_q   <= 12'h000;
    end else begin
      state_q <= state_d;
      if (push_q && bufReady)
        push_q <= 1'b0;
      if (strobeFall) begin
        riseCnt_q   <= `ADCSC_CNT_ZERO;
        fallCnt_q   <= `ADCSC_CNT_ZERO;
        trackEn     <= 1'b0;
        dataOut     <= 1'b0;
        dataOutEn   <= 1'b1;
        sar_q       <= 12'h000;
        earlyRise_q <= 1'b0;
        floatArm_q  <= 1'b0;
        dacCode     <= 10'h200;                              // first trial at msb
      end else if (state_q == `ADCSC_ST_CONV) begin
        // a rising serial clock edge advances the rise count; falling edges advance the fall count below
        if (sclkRise) begin
          riseCnt_q <= riseCnt_q + `ADCSC_CNT_ONE;
          if (riseCnt_q + `ADCSC_CNT_ONE == `ADCSC_TRACK_EDGE)
            trackEn <= 1'b1;
          // one result bit resolved and shifted per edge
          if (riseCnt_q + `ADCSC_CNT_ONE >= `ADCSC_MSB_EDGE &&
              riseCnt_q + `ADCSC_CNT_ONE <= `ADCSC_LAST_DATA) begin
            dacCode[bitIdx - 4'd1 > 4'd9 ? 4'd0 : bitIdx - 4'd1] <= 1'b1;
            dacCode[bitIdx]       <= compResult;
            sar_q[bitIdx + 4'd2]  <= compResult;
            dataOut               <= compResult;
            compTrialBit          <= compResult;
          end else if (riseCnt_q + `ADCSC_CNT_ONE == `ADCSC_SUB_HI_EDGE) begin
            sar_q[1] <= compResult;
            dataOut  <= compResult;                          // sub_bit_high
          end else if (riseCnt_q + `ADCSC_CNT_ONE == `ADCSC_SUB_LO_EDGE) begin
            sar_q[0] <= compResult;
            dataOut  <= compResult;                          // sub_bit_low
          end else begin
            dataOut  <= 1'b0;                                // leading, trailing zero
          end
        end
        if (sclkFall)
          fallCnt_q <= fallCnt_q + `ADCSC_CNT_ONE;
        // strobe raised between edge 3 and 14 cuts the conversion short
        // the mode steps at the strobe rise itself; the host need not finish the frame
        if (strobeRise && riseCnt_q >= `ADCSC_PD_LO_EDGE && riseCnt_q < `ADCSC_TRACK_EDGE) begin
          earlyRise_q <= 1'b1;
          dataOut     <= 1'b0;
          dataOutEn   <= 1'b0;
          trackEn     <= 1'b1;
          powerMode   <= (powerMode == `ADCSC_MODE_RUN) ? `ADCSC_MODE_PARTIAL
                                                        : `ADCSC_MODE_FULL;
        end
        // 16th falling edge: hand the word on, decide power mode
        if (state_d == `ADCSC_ST_DONE) begin
          push_q     <= ~earlyRise_q;
          pushData_q <= sar_q;
          trackEn    <= 1'b1;
          if (earlyRise_q)
            powerMode <= (powerMode == `ADCSC_MODE_RUN) ? `ADCSC_MODE_PARTIAL
                                                        : `ADCSC_MODE_FULL;
          else
            powerMode <= `ADCSC_MODE_RUN;  // a full frame wakes the part
          if (!convStrobe)
            floatArm_q <= 1'b1;
        end
      end else if (state_q == `ADCSC_ST_DONE) begin
        // strobe still low: float on next strobe or clock rise
        if (strobeRise || sclkRise || (convStrobe && !floatArm_q))
          dataOutEn <= 1'b0;
        if (strobeRise || sclkRise)
          dataOut <= 1'b0;
      end else begin
        dataOutEn <= 1'b0;                                   // idle never drives
        trackEn   <= 1'b1;
      end
    end
  end

  // ==========================================================
  // result buffer and output register
  // ==========================================================
  adcsc_skid_buffer uBuf (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .inValid  (push_q),
    .inReady  (bufReady),
    .inData   (pushData_q),
    .outValid (bufValid),
    .outReady (~resultValid | resultReady),
    .outData  (bufData)
  );

  // registered result port; a stall here backs up into the buffer
  always @(posedge sys_clk) begin
    if (reset) begin
      resultValid <= 1'b0;
      resultData  <= 12'h000;
    end else if (~resultValid | resultReady) begin
      resultValid <= bufValid;
      resultData  <= bufData;
    end
  end
endmodule

// ===== tb/adcsc_monitor.sv
// port assertions for the serial conversion control block
`timescale 1ns/10ps
module adcsc_monitor (
  // clock and reset
  input wire       sys_clk,
  input wire       reset,
  // host pins
  input wire       convStrobe,
  input wire       serialClk,
  input wire       dataOut,
  input wire       dataOutEn,
  // status
  input wire       trackEn,
  input wire [1:0] powerMode,
  input wire       resultValid
);
  reg [4:0] cnt;
  reg [2:0] roseQ;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ==========
  // rise count restarts at each strobe fall; saturates so stray edges never wrap
  always @(posedge sys_clk) begin
    roseQ <= {roseQ[1:0], $rose(serialClk)};
    if (reset || $fell(convStrobe)) cnt <= 5'h00;
    else if ($rose(serialClk) && cnt != 5'h1f) cnt <= cnt + 5'h01;
  end
  rst_state_a: assert property (
    $fell(reset) |-> !dataOutEn && trackEn && powerMode == 2'h0 && !resultValid) else $error("reset state");
  start_drive_a: assert property (
    $fell(convStrobe) |-> ##[1:2] dataOutEn && !dataOut) else $error("no drive at start");
  hold_start_a: assert property (
    $fell(convStrobe) |-> ##[1:2] !trackEn) else $error("no hold at start");
  lead_zero_a: assert property (
    $rose(serialClk) && cnt < 5'h03 && dataOutEn |-> ##2 !dataOut) else $error("lead bit");
  edge_only_a: assert property (
    $changed(dataOut) && $past(dataOutEn) && dataOutEn |-> roseQ != 3'h0) else $error("stray change");
  track_back_a: assert property (
    $rose(serialClk) && cnt == 5'h0d |-> ##[1:3] trackEn) else $error("no track");
  idle_track_a: assert property (
    trackEn && convStrobe |=> trackEn) else $error("track lost");
  float_a: assert property (
    $rose(serialClk) && cnt >= 5'h10 && !convStrobe |-> ##[1:3] !dataOutEn) else $error("no float");
  pwr_step_a: assert property (
    $rose(convStrobe) && cnt >= 5'h03 && cnt <= 5'h0d && powerMode == 2'h0 |-> ##[1:3] powerMode == 2'h1)
    else $error("no power step");
endmodule

// ===== tb/adcsc_host_model.sv
// host serial master: strobe and serial clock
`timescale 1ns/10ps
module adcsc_host_model #(parameter integer HALF = 4) (
  // clock
  input wire sys_clk,
  // host pins
  output reg convStrobe,
  output reg serialClk
);
  // armed and parked clock; the clock never runs outside frames
  initial begin
    convStrobe = 1'b1;
    serialClk = 1'b0;
  end
  task tick(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #1;
    end
  endtask
  // one frame; upAt picks the rise after which the strobe is raised
  task frame(input integer upAt, input integer n);
    integer r;
    begin
      tick(1);
      convStrobe = 1'b0;
      tick(2);
      for (r = 1; r <= n; r = r + 1) begin
        serialClk = 1'b1;
        tick(HALF);
        if (r == upAt) convStrobe = 1'b1;
        serialClk = 1'b0;
        tick(HALF);
      end
      convStrobe = 1'b1;
      tick(3);
    end
  endtask
endmodule

// ===== tb/test_adc_serial_conversion_control.sv
// self-checking bench for the serial conversion control block
`timescale 1ns/10ps
module test_adc_serial_conversion_control;
  reg         sys_clk = 1'b0;
  reg         reset = 1'b1;
  reg         resultReady = 1'b0;
  reg         stall = 1'b0;
  reg  [9:0]  vin = 10'h000;
  reg  [31:0] seed = 32'h2e1e9c59;
  reg  [15:0] bits = 16'h0000;
  reg  [9:0]  expQ[$];
  integer     failures = 0;
  integer     cmp_count = 0;
  integer     i;
  wire        convStrobe, serialClk, dataOut, dataOutEn, trackEn, resultValid;
  wire [9:0]  dacCode;
  wire [1:0]  powerMode;
  wire [11:0] resultData;
  // comparator: trial kept while the held input is not below it
  wire        compResult = (vin >= dacCode);
  always #20 sys_clk = ~sys_clk;
  adcsc_conv_ctrl u_dut (.sys_clk(sys_clk), .reset(reset), .convStrobe(convStrobe), .serialClk(serialClk),
    .dataOut(dataOut), .dataOutEn(dataOutEn), .trackEn(trackEn), .compTrialBit(), .compResult(compResult),
    .dacCode(dacCode), .powerMode(powerMode), .resultValid(resultValid), .resultReady(resultReady),
    .resultData(resultData));
  adcsc_host_model u_host (.sys_clk(sys_clk), .convStrobe(convStrobe), .serialClk(serialClk));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task fail(input [8*12:1] msg);
    begin
      failures = failures + 1;
      $display("wrong value at %0t: %0s", $time, msg);
    end
  endtask
  // sub-bits are masked: their value is not fixed by the input alone
  task chkBits(input [15:0] got, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if ((got & 16'hfff9) !== (exp & 16'hfff9)) fail("serial frame");
    end
  endtask
  task chkWord(input [9:0] got, input [9:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) fail("result word");
    end
  endtask
  task chkPin(input [3:0] got, input [3:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) fail("pin state");
    end
  endtask
  // random ready unless stalled; the same draw feeds the next input value
  always @(posedge sys_clk) begin
    #1;
    seed = xs(seed);
    resultReady = !stall && seed[4];
  end
  // serial line sampled mid-bit
  always @(negedge serialClk) bits = {bits[14:0], dataOut};
  always @(posedge sys_clk)
    if (!reset && resultValid === 1'b1 && resultReady === 1'b1) begin
      if (expQ.size() == 0) fail("extra word");
      else chkWord(resultData[11:2], expQ.pop_front());
    end
  task runFrame(input integer upAt, input integer n);
    begin
      @(negedge sys_clk) vin = seed[9:0];
      // expect the word before the frame: it may be taken before the frame task returns
      if (n >= 16) expQ.push_back(vin);
      u_host.frame(upAt, n);
      if (n == 16) chkBits(bits, {3'b000, vin, 3'b000});
    end
  endtask
  task drain;
    begin
      for (i = 0; i < 3000 && expQ.size() != 0; i = i + 1) @(posedge sys_clk);
      if (expQ.size() != 0) fail("drain hang");
    end
  endtask
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    #1 reset = 1'b0;
    @(posedge sys_clk);
    #1 chkPin({dataOutEn, trackEn, powerMode}, 4'h4);
    for (i = 0; i < 4; i = i + 1) runFrame(15, 16);
    runFrame(0, 16);
    chkPin({dataOutEn, trackEn, powerMode}, 4'h4);
    runFrame(0, 17);
    drain;
    stall = 1'b1;
    runFrame(15, 16);
    runFrame(15, 16);
    chkPin({resultValid, 3'h0}, 4'h8);
    stall = 1'b0;
    drain;
    runFrame(5, 5);
    chkPin({2'h0, powerMode}, 4'h1);
    runFrame(5, 5);
    chkPin({2'h0, powerMode}, 4'h2);
    repeat (16) @(posedge sys_clk);
    repeat (50000) @(posedge sys_clk);
    runFrame(15, 16);
    chkPin({2'h0, powerMode}, 4'h0);
    drain;
    print_verdict;
  end
endmodule
bind adcsc_conv_ctrl adcsc_monitor u_mon (.sys_clk(sys_clk), .reset(reset), .convStrobe(convStrobe),
  .serialClk(serialClk), .dataOut(dataOut), .dataOutEn(dataOutEn), .trackEn(trackEn),
  .powerMode(powerMode), .resultValid(resultValid));
